// File: dv/shmc_chk.sv
// port assertions for the half-duplex mac control block
// assumes binding into shmc_top; one clock, async high reset
`timescale 1ns/1ps
`default_nettype none
module shmc_chk #(
  parameter NPORTS = 5
) (
  input wire logic              mclk_i,        // clock
  input wire logic              sys_rst_i,     // reset
  input wire logic              reg_wr_i,      // reg write
  input wire logic              reg_rd_i,      // reg read
  input wire logic              reg_ack_o,     // reg answer
  input wire logic              stat_rd_i,     // stat request
  input wire logic              stat_ack_o,    // stat answer
  input wire logic [NPORTS-1:0] half_duplex_i, // half duplex
  input wire logic [NPORTS-1:0] tx_active_i,   // sending
  input wire logic [NPORTS-1:0] col_i,         // collision pin
  input wire logic [NPORTS-1:0] tx_retry_o,    // retry
  input wire logic [NPORTS-1:0] tx_drop_o,     // drop
  input wire logic [NPORTS-1:0] late_col_o,    // late
  input wire logic [NPORTS-1:0] rx_valid_i,    // rx valid
  input wire logic [NPORTS-1:0] rx_eof_i,      // rx last
  input wire logic [NPORTS-1:0] rx_discard_o,  // rx dropped
  input wire logic [NPORTS-1:0] rx_accept_o    // rx kept
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // request steps of the two access paths
  sequence s_reg_req;
    reg_wr_i || reg_rd_i;
  endsequence
  sequence s_stat_wait;
    stat_rd_i && !stat_ack_o;
  endsequence
  // any tx answer
  wire [NPORTS-1:0] tx_ev = tx_retry_o | tx_drop_o | late_col_o;
  chk_reg_ack_due: assert property (s_reg_req |=> reg_ack_o)
    else $error("reg ack missing");
  chk_reg_ack_cause: assert property (reg_ack_o |-> $past(reg_wr_i || reg_rd_i))
    else $error("reg ack without request");
  chk_stat_ack_due: assert property (s_stat_wait |-> ##[1:40] stat_ack_o)
    else $error("stat ack missing");
  chk_stat_ack_pulse: assert property (stat_ack_o |=> !stat_ack_o)
    else $error("stat ack too long");
  chk_late_not_retry: assert property ((late_col_o & (tx_retry_o | tx_drop_o)) == '0)
    else $error("late collision also retried");
  chk_tx_after_col: assert property (tx_ev != '0 |-> ($past(col_i, 3) & tx_ev) == tx_ev)
    else $error("tx answer without collision");
  chk_tx_port_gate: assert property ((tx_ev & ~$past(half_duplex_i & tx_active_i)) == '0)
    else $error("tx answer on idle port");
  chk_rx_verdict_time: assert property ((rx_discard_o | rx_accept_o) == $past(rx_valid_i & rx_eof_i))
    else $error("rx verdict timing");
  chk_rx_one_verdict: assert property ((rx_discard_o & rx_accept_o) == '0)
    else $error("rx double verdict");
endmodule
bind shmc_top shmc_chk #(.NPORTS(NPORTS)) chk_u (.mclk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_ack_o,
  .stat_rd_i, .stat_ack_o, .half_duplex_i, .tx_active_i, .col_i, .tx_retry_o, .tx_drop_o, .late_col_o,
  .rx_valid_i, .rx_eof_i, .rx_discard_o, .rx_accept_o);
`default_nettype wire

// File: dv/shmc_lp_model.sv
// half-duplex link partner: sends frames into rx, collides on tx
// assumes tasks are called just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module shmc_lp_model #(
  parameter NPORTS = 5
) (
  input  wire logic              mclk_i,     // clock
  output var  logic [NPORTS-1:0]   rx_valid_o, // byte valid
  output var  logic [NPORTS-1:0]   rx_sof_o,   // first byte
  output var  logic [NPORTS-1:0]   rx_eof_o,   // last byte
  output var  logic [NPORTS*8-1:0] rx_data_o,  // bytes
  output var  logic [NPORTS-1:0]   col_o       // collision pin
);
  // idle lines
  initial begin
    rx_valid_o = '0;
    rx_sof_o = '0;
    rx_eof_o = '0;
    rx_data_o = '0;
    col_o = '0;
  end
  // length or type in bytes 13 and 14
  task automatic send(input int p, input int n, input logic [15:0] fld);
    for (int i = 1; i <= n; i++) begin
      @(posedge mclk_i);
      #1;
      rx_valid_o[p] = 1'b1;
      rx_sof_o[p] = (i == 1);
      rx_eof_o[p] = (i == n);
      rx_data_o[p*8+:8] = (i == 13) ? fld[15:8] : (i == 14) ? fld[7:0] : i[7:0];
    end
    @(posedge mclk_i);
    #1;
    rx_valid_o[p] = 1'b0;
    rx_eof_o[p] = 1'b0;
    rx_data_o[p*8+:8] = ~rx_data_o[p*8+:8];
  endtask
  task automatic collide(input int p, input logic on);
    col_o[p] = on;
  endtask
endmodule
`default_nettype wire

// File: dv/shmc_top_tb_top.sv
// self-checking bench for shmc_top with a link partner model
// assumes shmc_chk is bound in; one 250 MHz clock
`timescale 1ns/1ps
`default_nettype none
module shmc_top_tb_top;
  localparam NP = 5;
  logic             mclk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic             stat_rd_i = 1'b0, tail_tag_en_i = 1'b0, reg_ack_o, stat_ack_o;
  logic [1:0]       reg_src_i = '0;
  logic [11:0]      reg_addr_i = '0;
  logic [7:0]       reg_wdata_i = '0, stat_index_i = '0, reg_rdata_o, q;
  logic [2:0]       stat_port_i = '0;
  logic [NP-1:0]    half_duplex_i = '1, tx_active_i = '0, tx_byte_i = '0, tx_ok_i = '0;
  logic [NP-1:0]    col_i, rx_valid_i, rx_sof_i, rx_eof_i, rx_discard_o, rx_accept_o;
  logic [NP-1:0]    tx_retry_o, tx_drop_o, late_col_o;
  logic [NP*8-1:0]  rx_data_i;
  logic [NP*10-1:0] backoff_slots_o;
  logic [31:0]      stat_rdata_o;
  int               mismatches = 0, samples_checked = 0;
  // rx cases: tail, bytes, field, discard
  int               lc [7][4] = '{'{0, 28, 10, 0}, '{0, 29, 10, 1}, '{0, 29, 'h800, 0}, '{1, 29, 10, 0},
                                  '{1, 28, 10, 1}, '{0, 30, 'h5dc, 1}, '{0, 30, 'h5dd, 0}};
  always #2 mclk_i = ~mclk_i;
  shmc_top #(.NPORTS(NP), .PW(3), .CW(32)) dut_u (.mclk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_src_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .stat_rd_i, .stat_port_i, .stat_index_i, .stat_rdata_o,
    .stat_ack_o, .tail_tag_en_i, .half_duplex_i, .tx_active_i, .tx_byte_i, .tx_ok_i, .col_i, .tx_retry_o,
    .tx_drop_o, .late_col_o, .backoff_slots_o, .rx_valid_i, .rx_sof_i, .rx_eof_i, .rx_data_i, .rx_discard_o,
    .rx_accept_o);
  shmc_lp_model #(.NPORTS(NP)) lp_u (.mclk_i, .rx_valid_o(rx_valid_i), .rx_sof_o(rx_sof_i),
    .rx_eof_o(rx_eof_i), .rx_data_o(rx_data_i), .col_o(col_i));
  // verdict and compare helpers
  task automatic test_done;
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask
  // one register access, answer one cycle later
  task automatic reg_acc(input logic wr, input logic [1:0] src, input logic [11:0] a, input logic [7:0] d);
    reg_wr_i = wr;
    reg_rd_i = !wr;
    reg_src_i = src;
    reg_addr_i = a;
    reg_wdata_i = d;
    tick;
    check("reg_ack_o", 1, reg_ack_o);
    q = reg_rdata_o;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    tick;
  endtask
  task automatic rd_chk(input string n, input logic [11:0] a, input logic [7:0] e);
    reg_acc(1'b0, 2'h0, a, 8'h00);
    check(n, e, q);
  endtask
  // late collision counter read, held until answer
  task automatic stat_chk(input int p, input logic [31:0] e);
    stat_port_i = p[2:0];
    stat_index_i = 8'h16;
    stat_rd_i = 1'b1;
    for (int i = 0; i <= 40; i++) begin
      tick;
      if (stat_ack_o === 1'b1) break;
      if (i == 40) begin
        check("stat_ack_o", 1, 0);
        test_done;
      end
    end
    stat_rd_i = 1'b0;
    check("late count", e, stat_rdata_o);
  endtask
  task automatic tx_bytes(input int p, input int n);
    repeat (n) begin
      tx_byte_i[p] = 1'b1;
      tick;
      tx_byte_i[p] = 1'b0;
      tick;
    end
  endtask
  // collision on port p; e is late, drop, retry; k the attempt now
  task automatic coll(input int p, input logic [2:0] e, input int k);
    logic [2:0] g;
    lp_u.collide(p, 1'b1);
    for (int i = 0; i <= 10; i++) begin
      tick;
      g = {late_col_o[p], tx_drop_o[p], tx_retry_o[p]};
      if (g !== 3'b000) break;
      if (i == 10) begin
        check("tx answer", 1, 0);
        test_done;
      end
    end
    lp_u.collide(p, 1'b0);
    check("tx answer", e, g);
    if (e[0]) check("backoff_slots_o", 0, backoff_slots_o[p*10+:10] >> ((k > 10) ? 10 : k));
    repeat (3) tick;
  endtask
  // reset values, each source, refused miim, unmapped place
  task automatic t_regs;
    rd_chk("coll ctrl reset", 12'h300, 8'h00);
    rd_chk("mac ctrl0 reset", 12'h330, 8'h00);
    for (int s = 0; s < 4; s++) begin
      reg_acc(1'b1, s[1:0], 12'h300, {7'h00, ~s[0]});
      rd_chk("coll ctrl", 12'h300, (s == 3) ? 8'h01 : {7'h00, ~s[0]});
    end
    reg_acc(1'b1, 2'h1, 12'h330, 8'h88);
    rd_chk("mac ctrl0", 12'h330, 8'h88);
    reg_acc(1'b1, 2'h0, 12'h123, 8'h5a);
    rd_chk("unmapped", 12'h123, 8'h00);
    reg_acc(1'b1, 2'h0, 12'h300, 8'h00);
  endtask
  // length check over field, type, tail and boundary cases
  task automatic t_len;
    reg_acc(1'b1, 2'h2, 12'h330, 8'h08);
    for (int i = 0; i < 7; i++) begin
      tail_tag_en_i = lc[i][0][0];
      lp_u.send(i % NP, lc[i][1], lc[i][2][15:0]);
      check("rx_discard_o", lc[i][3], rx_discard_o[i % NP]);
      check("rx_accept_o", !lc[i][3], rx_accept_o[i % NP]);
    end
    tail_tag_en_i = 1'b0;
    reg_acc(1'b1, 2'h0, 12'h330, 8'h00);
    lp_u.send(0, 29, 16'd10);
    check("rx_accept_o off", 1, rx_accept_o[0]);
  endtask
  // slot window edge and per port counting
  task automatic t_late;
    tx_active_i[1] = 1'b1;
    tick;
    tx_bytes(1, 64);
    coll(1, 3'b100, 0);
    tx_active_i[0] = 1'b1;
    tick;
    tx_bytes(0, 63);
    coll(0, 3'b001, 1);
    tx_active_i = '0;
    tx_ok_i[0] = 1'b1;
    tick;
    tx_ok_i = '0;
    stat_chk(1, 1);
    stat_chk(0, 0);
    // late count seen, port 1 forced to full duplex
    half_duplex_i[1] = 1'b0;
    tx_active_i = 5'b00011;
    lp_u.collide(1, 1'b1);
    repeat (5) begin
      tick;
      check("port 1 tx answer", 0, {late_col_o[1], tx_drop_o[1], tx_retry_o[1]});
    end
    lp_u.collide(1, 1'b0);
    coll(0, 3'b001, 1);
    half_duplex_i = '1;
    tx_active_i = '0;
  endtask
  // excessive collisions with and without the no-drop setting
  task automatic t_xdrop;
    tx_active_i[3] = 1'b1;
    tick;
    for (int k = 1; k <= 16; k++) coll(3, (k == 16) ? 3'b010 : 3'b001, k);
    reg_acc(1'b1, 2'h0, 12'h300, 8'h01);
    reg_acc(1'b1, 2'h0, 12'h330, 8'h80);
    for (int k = 1; k <= 17; k++) coll(3, 3'b001, k);
    tx_active_i = '0;
  endtask
  // reset then scenarios
  initial begin
    repeat (20) @(posedge mclk_i);
    #1;
    sys_rst_i = 1'b0;
    repeat (8) tick;
    t_regs;
    t_len;
    t_late;
    t_xdrop;
    test_done;
  end
endmodule
`default_nettype wire

// File: verilog/shmc_cnt_ram.v
// small counter memory, one word per port
// assumes one clock; read data appear one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module shmc_cnt_ram #(
  parameter DEPTH = 5,
  parameter AW    = 3,
  parameter DW    = 32
) (
  input  wire          mclk_i,    // block clock
  input  wire          sys_rst_i, // async reset, high
  input  wire          we_i,      // write strobe
  input  wire [AW-1:0] waddr_i,   // write address
  input  wire [DW-1:0] wdata_i,   // write data
  input  wire          re_i,      // read strobe
  input  wire [AW-1:0] raddr_i,   // read address
  output reg  [DW-1:0] rdata_o    // registered read data
);
  reg [DW-1:0] mem [0:DEPTH-1];

  // array write, no reset on storage
  always @(posedge mclk_i) begin
    if (we_i)
      mem[waddr_i] <= wdata_i;
  end

  // registered read port
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      rdata_o <= {DW{1'b0}};
    else if (re_i)
      rdata_o <= mem[raddr_i];
  end
endmodule
`default_nettype wire

// File: verilog/shmc_defines.vh
// constants for the half-duplex port mac control block
// assumes inclusion by bare name from the design files
`ifndef SHMC_DEFINES_VH
`define SHMC_DEFINES_VH
`define SHMC_REG_COLL_CTRL   12'h300
`define SHMC_REG_MAC_CTRL0   12'h330
`define SHMC_NOXDROP_BIT     0
`define SHMC_ALT_BO_BIT      7
`define SHMC_LEN_CHK_BIT     3
`define SHMC_COLL_CTRL_RST   8'h00
`define SHMC_MAC_CTRL0_RST   8'h00
`define SHMC_STAT_LATE_COL   8'h16
`define SHMC_SLOT_BITS       512
`define SHMC_SLOT_BYTES      7'h40
`define SHMC_MAX_ATTEMPTS    5'h10
`define SHMC_BO_LIMIT        4'ha
`define SHMC_MAX_LEN_VALUE   16'h05dc
`define SHMC_HDR_BYTES       16'h000e
`define SHMC_FCS_BYTES       16'h0004
`define SHMC_TAIL_BYTES      16'h0001
`define SHMC_LEN_HI_IDX      12'h00c
`define SHMC_LEN_LO_IDX      12'h00d
`define SHMC_SRC_SPI         2'h0
`define SHMC_SRC_I2C         2'h1
`define SHMC_SRC_IBA         2'h2
`define SHMC_SRC_MIIM        2'h3
`define SHMC_LFSR_SEED       16'hace1
`endif

// File: verilog/shmc_top.v
// half-duplex collision handling, late collision counting and rx length check
// assumes tx/rx strobes come from logic on mclk_i; col_i comes from a pin
`timescale 1ns/1ps
`default_nettype none
`include "shmc_defines.vh"
module shmc_top #(
  parameter NPORTS = 5,
  parameter PW     = 3,
  parameter CW     = 32
) (
  input  wire                 mclk_i,          // 250 MHz block clock
  input  wire                 sys_rst_i,       // async reset, high
  input  wire                 reg_wr_i,        // control register write
  input  wire                 reg_rd_i,        // control register read
  input  wire [1:0]           reg_src_i,       // management access source
  input  wire [11:0]          reg_addr_i,      // register byte address
  input  wire [7:0]           reg_wdata_i,     // write data
  output reg  [7:0]           reg_rdata_o,     // read data
  output reg                  reg_ack_o,       // access answered
  input  wire                 stat_rd_i,       // statistics read request
  input  wire [PW-1:0]        stat_port_i,     // port to read
  input  wire [7:0]           stat_index_i,    // statistics index
  output reg  [CW-1:0]        stat_rdata_o,    // statistics value
  output reg                  stat_ack_o,      // statistics answer
  input  wire                 tail_tag_en_i,   // ingress tail tagging on
  input  wire [NPORTS-1:0]    half_duplex_i,   // port in half duplex
  input  wire [NPORTS-1:0]    tx_active_i,     // frame on the wire
  input  wire [NPORTS-1:0]    tx_byte_i,       // one byte sent
  input  wire [NPORTS-1:0]    tx_ok_i,         // frame done cleanly
  input  wire [NPORTS-1:0]    col_i,           // collision pin
  output reg  [NPORTS-1:0]    tx_retry_o,      // back off and retry
  output reg  [NPORTS-1:0]    tx_drop_o,       // frame dropped
  output reg  [NPORTS-1:0]    late_col_o,      // late collision seen
  output reg  [NPORTS*10-1:0] backoff_slots_o, // slots to wait
  input  wire [NPORTS-1:0]    rx_valid_i,      // rx byte valid
  input  wire [NPORTS-1:0]    rx_sof_i,        // first byte
  input  wire [NPORTS-1:0]    rx_eof_i,        // last byte
  input  wire [NPORTS*8-1:0]  rx_data_i,       // rx bytes
  output reg  [NPORTS-1:0]    rx_discard_o,    // frame dropped
  output reg  [NPORTS-1:0]    rx_accept_o      // frame kept
);
  localparam [3:0] ST_CLR  = 4'b0001;
  localparam [3:0] ST_IDLE = 4'b0010;
  localparam [3:0] ST_INC  = 4'b0100;
  localparam [3:0] ST_SRD  = 4'b1000;
  // last counter word, cut to the pointer width where it is compared
  localparam integer LAST_PORT = NPORTS - 1;

  reg  [7:0]        coll_ctrl_q;
  reg  [7:0]        mac_ctrl0_q;
  reg  [NPORTS-1:0] pend_q;
  reg  [3:0]        state_q;
  reg  [PW-1:0]     ptr_q;
  wire [CW-1:0]     ram_rdata;
  reg               ram_we;
  reg  [PW-1:0]     ram_waddr;
  reg  [CW-1:0]     ram_wdata;
  reg               ram_re;
  reg  [PW-1:0]     ram_raddr;
  reg  [PW-1:0]     low_sel;

  wire no_xdrop = coll_ctrl_q[`SHMC_NOXDROP_BIT];
  wire alt_bo   = mac_ctrl0_q[`SHMC_ALT_BO_BIT];
  wire len_chk  = mac_ctrl0_q[`SHMC_LEN_CHK_BIT];

  // mask of the low k bits, k capped at the back-off limit
  function [9:0] bo_mask;
    input [4:0] k;
    begin
      bo_mask = (k >= {1'b0, `SHMC_BO_LIMIT}) ? 10'h3ff : ((10'h001 << k) - 10'h001);
    end
  endfunction

  // lowest pending port index
  function [PW-1:0] lowest;
    input [NPORTS-1:0] v;
    integer j;
    begin
      lowest = {PW{1'b0}};
      for (j = NPORTS - 1; j >= 0; j = j - 1)
        if (v[j])
          lowest = j[PW-1:0];
    end
  endfunction

  // control register writes and reads
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      coll_ctrl_q <= `SHMC_COLL_CTRL_RST;
      mac_ctrl0_q <= `SHMC_MAC_CTRL0_RST;
      reg_rdata_o <= 8'h00;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_ack_o <= reg_wr_i | reg_rd_i;
      if (reg_wr_i && reg_src_i != `SHMC_SRC_MIIM) begin
        if (reg_addr_i == `SHMC_REG_COLL_CTRL)
          coll_ctrl_q <= reg_wdata_i;
        if (reg_addr_i == `SHMC_REG_MAC_CTRL0)
          mac_ctrl0_q <= reg_wdata_i;
      end
      if (reg_rd_i) begin
        if (reg_addr_i == `SHMC_REG_COLL_CTRL)
          reg_rdata_o <= coll_ctrl_q;
        else if (reg_addr_i == `SHMC_REG_MAC_CTRL0)
          reg_rdata_o <= mac_ctrl0_q;
        else
          reg_rdata_o <= 8'h00;
      end
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPORTS; p = p + 1) begin : g_port
      reg        col_s1_q;
      reg        col_s2_q;
      reg        col_s3_q;
      reg  [6:0] byte_cnt_q;
      reg  [4:0] att_q;
      reg [15:0] lfsr_q;
      reg [11:0] rx_cnt_q;
      reg [15:0] len_q;
      // port index, cut to the lfsr width for the seed
      localparam integer PIDX = p;
      wire       col_rise = col_s2_q & ~col_s3_q;
      wire [4:0] att_nx   = att_q + 5'h01;
      wire [9:0] rev_bits = {lfsr_q[6], lfsr_q[7], lfsr_q[8], lfsr_q[9], lfsr_q[10],
                             lfsr_q[11], lfsr_q[12], lfsr_q[13], lfsr_q[14], lfsr_q[15]};
      wire [9:0] std_draw = lfsr_q[9:0];
      wire [9:0] alt_draw = rev_bits ^ {att_nx, att_nx};
      wire [11:0] rx_nx   = rx_sof_i[p] ? 12'h001 : rx_cnt_q + 12'h001;
      wire [7:0]  rx_byte = rx_data_i[p*8 +: 8];
      wire [15:0] meas    = {4'h0, rx_nx} - `SHMC_HDR_BYTES - `SHMC_FCS_BYTES
                            - (tail_tag_en_i ? `SHMC_TAIL_BYTES : 16'h0000);

      // collision pin synchroniser, edge taken past the second stage
      always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          col_s1_q <= 1'b0;
          col_s2_q <= 1'b0;
          col_s3_q <= 1'b0;
        end else begin
          col_s1_q <= col_i[p];
          col_s2_q <= col_s1_q;
          col_s3_q <= col_s2_q;
        end
      end

      always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          byte_cnt_q <= 7'h00;
          att_q      <= 5'h00;
          lfsr_q     <= `SHMC_LFSR_SEED ^ PIDX[15:0];
          tx_retry_o[p] <= 1'b0;
          tx_drop_o[p]  <= 1'b0;
          late_col_o[p] <= 1'b0;
          backoff_slots_o[p*10 +: 10] <= 10'h000;
        end else begin
          lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
          tx_retry_o[p] <= 1'b0;
          tx_drop_o[p]  <= 1'b0;
          late_col_o[p] <= 1'b0;
          if (!tx_active_i[p])
            byte_cnt_q <= 7'h00;
          else if (tx_byte_i[p] && byte_cnt_q < `SHMC_SLOT_BYTES)
            byte_cnt_q <= byte_cnt_q + 7'h01;
          if (tx_ok_i[p])
            att_q <= 5'h00;
          if (col_rise && tx_active_i[p] && half_duplex_i[p]) begin
            if (byte_cnt_q >= `SHMC_SLOT_BYTES) begin
              late_col_o[p] <= 1'b1;
            end else if (att_nx >= `SHMC_MAX_ATTEMPTS && !no_xdrop) begin
              tx_drop_o[p] <= 1'b1;
              att_q        <= 5'h00;
            end else begin
              tx_retry_o[p] <= 1'b1;
              att_q <= (att_nx >= `SHMC_MAX_ATTEMPTS) ? att_q : att_nx;
              backoff_slots_o[p*10 +: 10] <= (alt_bo ? alt_draw : std_draw) & bo_mask(att_nx);
            end
          end
        end
      end

      // receive length field check
      always @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          rx_cnt_q <= 12'h000;
          len_q    <= 16'h0000;
          rx_discard_o[p] <= 1'b0;
          rx_accept_o[p]  <= 1'b0;
        end else begin
          rx_discard_o[p] <= 1'b0;
          rx_accept_o[p]  <= 1'b0;
          if (rx_valid_i[p]) begin
            rx_cnt_q <= rx_nx;
            if (rx_nx == `SHMC_LEN_HI_IDX + 12'h001)
              len_q[15:8] <= rx_byte;
            if (rx_nx == `SHMC_LEN_LO_IDX + 12'h001)
              len_q[7:0] <= rx_byte;
            if (rx_eof_i[p]) begin
              if (len_chk && len_q <= `SHMC_MAX_LEN_VALUE && meas != len_q)
                rx_discard_o[p] <= 1'b1;
              else
                rx_accept_o[p] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // counter memory port steering
  always @* begin
    low_sel   = lowest(pend_q);
    ram_we    = 1'b0;
    ram_waddr = ptr_q;
    ram_wdata = {CW{1'b0}};
    ram_re    = 1'b0;
    ram_raddr = stat_port_i;
    case (state_q)
      ST_CLR: begin
        ram_we = 1'b1;
      end
      ST_IDLE: begin
        if (|pend_q) begin
          ram_re    = 1'b1;
          ram_raddr = low_sel;
        end else if (stat_rd_i && stat_index_i == `SHMC_STAT_LATE_COL) begin
          ram_re = 1'b1;
        end
      end
      ST_INC: begin
        ram_we    = 1'b1;
        ram_wdata = ram_rdata + {{(CW-1){1'b0}}, 1'b1};
      end
      default: begin
        ram_we = 1'b0;
      end
    endcase
  end

  // late collision counting and statistics reads
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q      <= ST_CLR;
      ptr_q        <= {PW{1'b0}};
      pend_q       <= {NPORTS{1'b0}};
      stat_rdata_o <= {CW{1'b0}};
      stat_ack_o   <= 1'b0;
    end else begin
      stat_ack_o <= 1'b0;
      // set wins over the clear of the same port
      pend_q <= (pend_q & ~((state_q == ST_INC) ? ({{(NPORTS-1){1'b0}}, 1'b1} << ptr_q)
                                                 : {NPORTS{1'b0}})) | late_col_o;
      case (state_q)
        ST_CLR: begin
          ptr_q <= ptr_q + {{(PW-1){1'b0}}, 1'b1};
          if (ptr_q == LAST_PORT[PW-1:0]) begin
            ptr_q   <= {PW{1'b0}};
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (|pend_q) begin
            ptr_q   <= low_sel;
            state_q <= ST_INC;
          end else if (stat_rd_i) begin
            if (stat_index_i == `SHMC_STAT_LATE_COL) begin
              state_q <= ST_SRD;
            end else begin
              stat_rdata_o <= {CW{1'b0}};
              stat_ack_o   <= 1'b1;
            end
          end
        end
        ST_INC: begin
          state_q <= ST_IDLE;
        end
        ST_SRD: begin
          stat_rdata_o <= ram_rdata;
          stat_ack_o   <= 1'b1;
          state_q      <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // per-port late collision counters
  shmc_cnt_ram #(
    .DEPTH (NPORTS),
    .AW    (PW),
    .DW    (CW)
  ) u_cnt_ram (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .we_i      (ram_we),
    .waddr_i   (ram_waddr),
    .wdata_i   (ram_wdata),
    .re_i      (ram_re),
    .raddr_i   (ram_raddr),
    .rdata_o   (ram_rdata)
  );
endmodule
`default_nettype wire
